// [design/fcd_pkg.sv]
package fcd_pkg;
  // ==========================================================================
  // widths
  localparam int DATA_W = 32;
  localparam int FRAC_W = 16;
  localparam int CNT_W  = 4;
  localparam int ADDR_W = 4;

  // ==========================================================================
  // timing in clock cycles
  localparam logic [CNT_W-1:0] DIV_PIPE_CYC    = 4'h7;
  localparam logic [CNT_W-1:0] DIV_UNPIPE_CYC  = 4'h6;
  localparam logic [CNT_W-1:0] DIV_GAP_PIPE    = 4'h6;
  localparam logic [CNT_W-1:0] WORK_LAT_PIPE   = 4'h2;
  localparam logic [CNT_W-1:0] WORK_LAT_UNPIPE = 4'h1;

  // ==========================================================================
  // controller register map
  localparam logic [ADDR_W-1:0] REG_CTRL   = 4'h0;
  localparam logic [ADDR_W-1:0] REG_OPA    = 4'h1;
  localparam logic [ADDR_W-1:0] REG_OPB    = 4'h2;
  localparam logic [ADDR_W-1:0] REG_RESULT = 4'h3;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_KIND_BIT  = 1;
  localparam int CTRL_PIPE_BIT  = 2;
  localparam int CTRL_ABSA_BIT  = 3;
  localparam int CTRL_ABSB_BIT  = 4;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_GT_BIT    = 1;
  localparam int STAT_DONE_BIT  = 2;

  // ==========================================================================
  // microinstruction
  typedef enum logic [1:0] {ALU_NOP, ALU_PASS_A, ALU_PASS_C, ALU_COMPARE} fcd_alu_op_type;
  typedef enum logic [1:0] {MUL_NOP, MUL_PASS_S, MUL_PASS_A, MUL_DIVIDE} fcd_mul_op_type;

  typedef struct packed {
    logic           load_first;
    logic           load_second;
    fcd_alu_op_type alu_op;
    fcd_mul_op_type mul_op;
    logic           cmp_with_c;
    logic           abs_first;
    logic           abs_second;
    logic           chain_select_bit;
    logic           output_source_select;
    logic           y_load;
    logic           c_load;
    logic           c_from_p;
  } fcd_instr_type;
endpackage

// [design/fcd_link_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface fcd_link_if
  import fcd_pkg::*;
#(
  parameter int DW = DATA_W
) ();
  fcd_instr_type instr;
  logic          pipe_mode;
  logic [DW-1:0] operand_a;
  logic [DW-1:0] operand_b;
  logic [DW-1:0] y_bus;
  logic          greater_than_flag;
  logic          equal_zero_flag;

  modport dev (
    input  instr, pipe_mode, operand_a, operand_b,
    output y_bus, greater_than_flag, equal_zero_flag
  );
  modport ctl (
    output instr, pipe_mode, operand_a, operand_b,
    input  y_bus, greater_than_flag, equal_zero_flag
  );
endinterface : fcd_link_if
`default_nettype wire

// [design/fcd_datapath.sv]
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module fcd_datapath
  import fcd_pkg::*;
#(
  parameter int DW = DATA_W,
  parameter int FW = FRAC_W
) (
  input  wire logic mclk_i,
  input  wire logic rst_i,
  fcd_link_if.dev   link,
  output logic      div_busy_o
);

  // ==========================================================================
  // parameter check
  if (DW < 4 || FW < 1 || FW > DW - 2) begin : g_bad_width
    $error("fcd_datapath: unsupported DW/FW");
  end
  if (DIV_PIPE_CYC <= WORK_LAT_PIPE || DIV_UNPIPE_CYC <= WORK_LAT_UNPIPE) begin : g_bad_lat
    $error("fcd_datapath: divide latency too short");
  end

  // ==========================================================================
  // state
  typedef struct packed {
    logic [DW-1:0]    first_input_latch;
    logic [DW-1:0]    second_input_latch;
    fcd_instr_type    stage;
    logic [DW-1:0]    s;
    logic [DW-1:0]    p;
    logic [DW-1:0]    c;
    logic [DW-1:0]    y;
    logic             gt;
    logic             eq;
    logic [DW-1:0]    div_val;
    logic [CNT_W-1:0] div_cnt;
    logic             busy;
  } fcd_dp_state_type;

  fcd_dp_state_type st_q;
  fcd_dp_state_type st_d;

  // ==========================================================================
  // sign-magnitude helpers; +0 and -0 are treated as equal
  function automatic logic [DW-1:0] fcd_abs(input logic [DW-1:0] v);
    return {1'b0, v[DW-2:0]};
  endfunction

  function automatic logic fcd_is_zero(input logic [DW-1:0] v);
    return v[DW-2:0] == '0;
  endfunction

  function automatic logic fcd_eq(input logic [DW-1:0] a, input logic [DW-1:0] b);
    return (fcd_is_zero(a) && fcd_is_zero(b)) || (a == b);
  endfunction

  function automatic logic fcd_gt(input logic [DW-1:0] a, input logic [DW-1:0] b);
    logic r;
    if (fcd_is_zero(a) && fcd_is_zero(b)) begin
      r = 1'b0;
    end else if (a[DW-1] != b[DW-1]) begin
      r = !a[DW-1];
    end else if (!a[DW-1]) begin
      r = a[DW-2:0] > b[DW-2:0];
    end else begin
      r = a[DW-2:0] < b[DW-2:0];
    end
    return r;
  endfunction

  // fixed-point quotient; division by zero saturates the magnitude
  function automatic logic [DW-1:0] fcd_quot(input logic [DW-1:0] a, input logic [DW-1:0] b);
    logic [DW+FW-2:0] num;
    logic [DW+FW-2:0] quo;
    logic [DW-2:0]    mag;
    num = {a[DW-2:0], {FW{1'b0}}};
    quo = '0;
    if (b[DW-2:0] == '0) begin
      mag = '1;
    end else begin
      quo = num / {{FW{1'b0}}, b[DW-2:0]};
      mag = (quo[DW+FW-2:DW-1] != '0) ? '1 : quo[DW-2:0];
    end
    return {a[DW-1] ^ b[DW-1], mag};
  endfunction

  // ==========================================================================
  // working instruction: staged one cycle in pipelined mode, direct when unpiped
  fcd_instr_type    wi;
  logic [DW-1:0]    wa;
  logic [DW-1:0]    wb;
  logic [DW-1:0]    cmp_x;
  logic [DW-1:0]    cmp_y;
  logic [DW-1:0]    alu_res;
  logic [DW-1:0]    mul_res;
  logic             cmp_go;
  logic             alu_go;
  logic             mul_go;
  logic             conflict;
  logic [CNT_W-1:0] div_lat;

  always_comb begin
    st_d     = st_q;
    wi       = st_q.stage;
    wa       = st_q.first_input_latch;
    wb       = st_q.second_input_latch;
    div_lat  = DIV_PIPE_CYC - WORK_LAT_PIPE;
    alu_res  = '0;
    mul_res  = '0;
    if (!link.pipe_mode) begin
      wi      = link.instr;
      wa      = link.instr.load_first ? link.operand_a : st_q.first_input_latch;
      wb      = link.instr.load_second ? link.operand_b : st_q.second_input_latch;
      div_lat = DIV_UNPIPE_CYC - WORK_LAT_UNPIPE;
    end

    // stage register follows every edge; input latches load only when their load bit is set
    if (link.instr.load_first) begin
      st_d.first_input_latch = link.operand_a;
    end
    if (link.instr.load_second) begin
      st_d.second_input_latch = link.operand_b;
    end
    st_d.stage = link.instr;

    // feedback register bypasses the pipeline stage entirely
    if (link.instr.c_load) begin
      st_d.c = link.instr.c_from_p ? st_q.p : st_q.s;
    end

    // one read path per input register: a compare against the second latch
    // cannot run while the multiplier takes the first one
    conflict = (wi.mul_op == MUL_PASS_A) && (wi.alu_op == ALU_COMPARE) &&
               !wi.cmp_with_c;
    cmp_go   = (wi.alu_op == ALU_COMPARE) && !wi.chain_select_bit && !conflict;
    alu_go   = (wi.alu_op == ALU_PASS_A) || (wi.alu_op == ALU_PASS_C);
    mul_go   = (wi.mul_op == MUL_PASS_S) || (wi.mul_op == MUL_PASS_A);

    // compare, optionally on magnitudes
    cmp_x = wi.abs_first ? fcd_abs(wa) : wa;
    cmp_y = wi.cmp_with_c ? st_q.c : wb;
    if (wi.abs_second) begin
      cmp_y = fcd_abs(cmp_y);
    end

    // ALU path into S
    if (wi.alu_op == ALU_PASS_A) begin
      alu_res = wa;
    end else if (wi.alu_op == ALU_PASS_C) begin
      alu_res = st_q.c;
    end
    if (alu_go) begin
      st_d.s = alu_res;
    end

    // multiplier path into P
    if (wi.mul_op == MUL_PASS_S) begin
      mul_res = st_q.s;
    end else if (wi.mul_op == MUL_PASS_A) begin
      mul_res = wa;
    end

    // divide delivery counts down, then a fresh divide may reload it
    if (st_q.div_cnt != '0) begin
      st_d.div_cnt = st_q.div_cnt - 1'b1;
      if (st_q.div_cnt == 4'h1) begin
        st_d.p  = st_q.div_val;
        st_d.eq = fcd_is_zero(st_q.div_val);
      end
    end
    if (mul_go) begin
      st_d.p = mul_res;
    end
    if (wi.mul_op == MUL_DIVIDE) begin
      st_d.div_val = fcd_quot(wa, wb);
      st_d.div_cnt = div_lat;
    end
    st_d.busy = st_d.div_cnt != '0;

    // status flags land on the working edge: two cycles after issue when piped
    if (cmp_go) begin
      st_d.gt = fcd_gt(cmp_x, cmp_y);
      st_d.eq = fcd_eq(cmp_x, cmp_y);
    end else if (alu_go) begin
      st_d.eq = fcd_is_zero(alu_res);
    end else if (mul_go) begin
      st_d.eq = fcd_is_zero(mul_res);
    end

    // output bus takes the values that P and S are about to hold
    if (wi.y_load) begin
      st_d.y = wi.output_source_select ? st_d.p : st_d.s;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================================
  // outputs
  assign link.y_bus             = st_q.y;
  assign link.greater_than_flag = st_q.gt;
  assign link.equal_zero_flag   = st_q.eq;
  assign div_busy_o             = st_q.busy;

endmodule : fcd_datapath
`default_nettype wire

// [design/fcd_controller.sv]
`timescale 1ns/1ps
`default_nettype none
module fcd_controller
  import fcd_pkg::*;
#(
  parameter int DW = DATA_W
) (
  input  wire logic              mclk_i,
  input  wire logic              rst_i,
  fcd_link_if.ctl                link,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DW-1:0]     wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [DW-1:0]     rdata_o
);

  // ==========================================================================
  // parameter check
  if (DW < 8) begin : g_bad_width
    $error("fcd_controller: DW too small");
  end

  // ==========================================================================
  // state
  typedef enum {CTL_IDLE, CTL_RUN} fcd_ctl_state_type;

  typedef struct packed {
    fcd_ctl_state_type state;
    logic [CNT_W-1:0]  step;
    fcd_instr_type     instr;
    logic [DW-1:0]     link_a;
    logic [DW-1:0]     link_b;
    logic              pipe;
    logic              kind;
    logic              abs_a;
    logic              abs_b;
    logic [DW-1:0]     opa;
    logic [DW-1:0]     opb;
    logic [DW-1:0]     result;
    logic              gt;
    logic              done;
    logic [DW-1:0]     rdata;
  } fcd_ctl_reg_type;

  fcd_ctl_reg_type r_q;
  fcd_ctl_reg_type r_d;

  logic [CNT_W-1:0] lat;
  logic [CNT_W-1:0] dlat;
  logic [CNT_W-1:0] nstep;
  logic             capture;

  always_comb begin
    r_d     = r_q;
    r_d.rdata = '0;
    lat     = r_q.pipe ? WORK_LAT_PIPE : WORK_LAT_UNPIPE;
    dlat    = r_q.pipe ? DIV_PIPE_CYC : DIV_UNPIPE_CYC;
    nstep   = r_q.step + 1'b1;
    capture = 1'b0;

    // ========================================================================
    // register reads, data one cycle later
    if (rd_i) begin
      case (addr_i)
        REG_CTRL: begin
          r_d.rdata[CTRL_KIND_BIT] = r_q.kind;
          r_d.rdata[CTRL_PIPE_BIT] = r_q.pipe;
          r_d.rdata[CTRL_ABSA_BIT] = r_q.abs_a;
          r_d.rdata[CTRL_ABSB_BIT] = r_q.abs_b;
        end
        REG_OPA:    r_d.rdata = r_q.opa;
        REG_OPB:    r_d.rdata = r_q.opb;
        REG_RESULT: r_d.rdata = r_q.result;
        REG_STATUS: begin
          r_d.rdata[STAT_BUSY_BIT] = r_q.state == CTL_RUN;
          r_d.rdata[STAT_GT_BIT]   = r_q.gt;
          r_d.rdata[STAT_DONE_BIT] = r_q.done;
        end
        default: r_d.rdata = '0;
      endcase
    end

    // ========================================================================
    // sequencing
    case (r_q.state)
      CTL_RUN: begin
        r_d.step  = nstep;
        r_d.instr = '0;
        r_d.instr.chain_select_bit = 1'b1;
        if (!r_q.kind) begin
          if (nstep == dlat - lat) begin
            r_d.instr.y_load               = 1'b1;
            r_d.instr.output_source_select = 1'b1;
          end
          capture = r_q.step == dlat;
        end else begin
          // the greater-than flag is copied here for the status register; the select below reads it from the link in the same cycle
          if (r_q.step == lat) begin
            r_d.gt = link.greater_than_flag;
          end
          if (nstep == 4'h1) begin
            r_d.instr.load_first = 1'b1;
            r_d.instr.alu_op     = ALU_PASS_A;
          end
          if (nstep == lat + 4'h1) begin
            r_d.link_a                     = r_q.link_b;
            r_d.instr.load_first           = 1'b1;
            r_d.instr.alu_op               = ALU_PASS_A;
            r_d.instr.mul_op               = MUL_PASS_S;
            r_d.instr.y_load               = 1'b1;
            r_d.instr.output_source_select = link.greater_than_flag;
          end
          // y is only sampled once the status cycle is long past
          capture = r_q.step == lat + lat + 4'h1;
        end
        if (capture) begin
          r_d.result = link.y_bus;
          r_d.done   = 1'b1;
          r_d.state  = CTL_IDLE;
          r_d.instr  = '0;
        end
      end
      default: begin
        r_d.instr = '0;
      end
    endcase

    // ========================================================================
    // register writes; control is refused while a sequence runs, which also
    // spaces divide loads by more than the six-cycle lapse
    if (wr_i) begin
      case (addr_i)
        REG_OPA: r_d.opa = wdata_i;
        REG_OPB: r_d.opb = wdata_i;
        REG_CTRL: begin
          if (r_q.state == CTL_IDLE) begin
            r_d.kind  = wdata_i[CTRL_KIND_BIT];
            r_d.pipe  = wdata_i[CTRL_PIPE_BIT];
            r_d.abs_a = wdata_i[CTRL_ABSA_BIT];
            r_d.abs_b = wdata_i[CTRL_ABSB_BIT];
            if (wdata_i[CTRL_START_BIT]) begin
              r_d.state             = CTL_RUN;
              r_d.step              = '0;
              r_d.done              = 1'b0;
              r_d.link_a            = r_q.opa;
              r_d.link_b            = r_q.opb;
              r_d.instr             = '0;
              r_d.instr.load_first  = 1'b1;
              r_d.instr.load_second = 1'b1;
              if (wdata_i[CTRL_KIND_BIT]) begin
                r_d.instr.alu_op     = ALU_COMPARE;
                r_d.instr.abs_first  = wdata_i[CTRL_ABSA_BIT];
                r_d.instr.abs_second = wdata_i[CTRL_ABSB_BIT];
                r_d.instr.chain_select_bit = 1'b0;
              end else begin
                r_d.instr.mul_op = MUL_DIVIDE;
              end
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  // ==========================================================================
  // outputs
  assign link.instr     = r_q.instr;
  assign link.pipe_mode = r_q.pipe;
  assign link.operand_a = r_q.link_a;
  assign link.operand_b = r_q.link_b;
  assign rdata_o        = r_q.rdata;

endmodule : fcd_controller
`default_nettype wire

// [tb/fcd_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module fcd_checker
  import fcd_pkg::*;
#(
  parameter int DW = DATA_W
) (
  input wire logic          mclk_i,
  input wire logic          rst_i,
  input wire fcd_instr_type instr,
  input wire logic          pipe_mode,
  input wire logic [DW-1:0] operand_a,
  input wire logic [DW-1:0] operand_b,
  input wire logic [DW-1:0] y_bus,
  input wire logic          greater_than_flag,
  input wire logic          equal_zero_flag
);
  // ==========================================================================
  // reference arithmetic, sign-magnitude so +0 and -0 compare equal
  function automatic logic mag_gt(input logic [DW-1:0] a, input logic [DW-1:0] b);
    if (a[DW-2:0] == '0 && b[DW-2:0] == '0) return 1'b0;
    if (a[DW-1] != b[DW-1]) return !a[DW-1];
    return a[DW-1] ? (a[DW-2:0] < b[DW-2:0]) : (a[DW-2:0] > b[DW-2:0]);
  endfunction

  // truncating quotient: the bench drives only exact quotients and one division by zero
  function automatic logic [DW-1:0] quot(input logic [DW-1:0] a, input logic [DW-1:0] b);
    logic [DW+FRAC_W-2:0] q;
    q = (b[DW-2:0] == '0) ? '1 : {a[DW-2:0], {FRAC_W{1'b0}}} / b[DW-2:0];
    return {a[DW-1] ^ b[DW-1], (q > {(DW-1){1'b1}}) ? {(DW-1){1'b1}} : q[DW-2:0]};
  endfunction

  logic [DW-1:0] fa;
  logic [DW-1:0] fb;
  logic [DW-1:0] q_now;
  logic          gt_now;
  logic          eq_now;
  logic          cmp_go;
  logic          cmp_ab;
  logic          s_from_a;
  logic          a_zero;
  assign fa       = {operand_a[DW-1] & ~instr.abs_first, operand_a[DW-2:0]};
  assign fb       = {operand_b[DW-1] & ~instr.abs_second, operand_b[DW-2:0]};
  assign gt_now   = mag_gt(fa, fb);
  assign eq_now   = (fa[DW-2:0] == '0 && fb[DW-2:0] == '0) || fa == fb;
  assign q_now    = quot(operand_a, operand_b);
  assign cmp_go   = instr.alu_op == ALU_COMPARE && !instr.chain_select_bit;
  assign cmp_ab   = cmp_go && !instr.cmp_with_c && instr.mul_op != MUL_PASS_A
                    && instr.load_first && instr.load_second;
  assign s_from_a = instr.alu_op == ALU_PASS_A && instr.load_first;
  assign a_zero   = operand_a[DW-2:0] == '0;

  // ==========================================================================
  // properties
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  gt_pipe_a: assert property (pipe_mode && cmp_ab
    |-> ##2 greater_than_flag == $past(gt_now, 2))
    else $error("greater-than flag wrong after pipelined compare");
  eq_pipe_a: assert property (pipe_mode && cmp_ab
    |-> ##2 equal_zero_flag == $past(eq_now, 2))
    else $error("equal flag wrong after pipelined compare");
  gt_unpipe_a: assert property (!pipe_mode && cmp_ab
    |=> greater_than_flag == $past(gt_now))
    else $error("greater-than flag wrong after unpiped compare");
  gt_cause_a: assert property (pipe_mode && $past(pipe_mode) && $past(pipe_mode, 2)
    && $changed(greater_than_flag) |-> $past(cmp_go, 2))
    else $error("greater-than flag moved without an unchained compare");
  zero_det_a: assert property (pipe_mode && s_from_a
    |-> ##2 equal_zero_flag == $past(a_zero, 2))
    else $error("equal flag is not a zero detect");
  y_alu_a: assert property (pipe_mode && instr.y_load && !instr.output_source_select
    && s_from_a |-> ##2 y_bus == $past(operand_a, 2))
    else $error("output bus does not carry the alu result");
  y_mul_a: assert property (pipe_mode && instr.y_load && instr.output_source_select
    && instr.mul_op == MUL_PASS_S && $past(s_from_a, 2) |-> ##2 y_bus == $past(operand_a, 4))
    else $error("output bus does not carry the multiplier result");
  y_time_a: assert property (pipe_mode && $past(pipe_mode) && $past(pipe_mode, 2)
    && $changed(y_bus) |-> $past(instr.y_load, 2))
    else $error("output bus moved without a load two cycles before");
  div_res_a: assert property (pipe_mode && instr.mul_op == MUL_DIVIDE
    && instr.load_first && instr.load_second |-> ##7 y_bus == $past(q_now, 7))
    else $error("pipelined quotient wrong or late");
  div_gap_a: assert property (pipe_mode && instr.mul_op == MUL_DIVIDE
    |=> (instr.mul_op != MUL_DIVIDE) [*5])
    else $error("divides issued too close together");

  cover property (pipe_mode && cmp_ab);
  cover property (!pipe_mode && cmp_ab);
  cover property (instr.mul_op == MUL_DIVIDE);
endmodule // fcd_checker
`default_nettype wire

// [tb/fcd_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module fcd_tb_top
  import fcd_pkg::*;
;
  typedef struct {
    logic [3:0]        ctl;
    logic [DATA_W-1:0] a;
    logic [DATA_W-1:0] b;
    logic [DATA_W-1:0] res;
    logic              gt;
    int                lat;
  } fcd_row_type;

  logic              mclk_i;
  logic              rst_i;
  logic              wr_i;
  logic              rd_i;
  logic              div_busy;
  logic [ADDR_W-1:0] addr_i;
  logic [DATA_W-1:0] wdata_i;
  logic [DATA_W-1:0] rdata_o;
  logic [DATA_W-1:0] d;
  fcd_row_type       rows [10];
  int                fail_count;
  int                checked;
  int                cycles = 0;
  int                n;

  // ==========================================================================
  // the two ends face each other over one link
  fcd_link_if link ();
  fcd_datapath fcd_datapath_i (.mclk_i(mclk_i), .rst_i(rst_i), .link(link), .div_busy_o(div_busy));
  fcd_controller fcd_controller_i (.mclk_i(mclk_i), .rst_i(rst_i), .link(link), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o));
  fcd_checker #(.DW(DATA_W)) fcd_checker_i (.mclk_i(mclk_i), .rst_i(rst_i), .instr(link.instr),
    .pipe_mode(link.pipe_mode), .operand_a(link.operand_a), .operand_b(link.operand_b),
    .y_bus(link.y_bus), .greater_than_flag(link.greater_than_flag),
    .equal_zero_flag(link.equal_zero_flag));

  initial mclk_i = 1'b0;
  always #20 mclk_i = ~mclk_i;

  // ==========================================================================
  // bus tasks: each strobe is set once per edge, so back-to-back calls are safe
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    rd_i <= 1'b0;
    @(posedge mclk_i);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    addr_i <= a;
    wr_i <= 1'b0;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    @(posedge mclk_i);
    v = rdata_o;
  endtask

  task automatic idle(input int k);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    repeat (k) @(posedge mclk_i);
  endtask

  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic poll();
    for (int k = 0; k < 40; k++) begin
      rd(REG_STATUS, d);
      if (d[STAT_DONE_BIT] === 1'b1) break;
    end
    chk(d[STAT_DONE_BIT], 1'b1);
    chk(d[STAT_BUSY_BIT], 1'b0);
    chk(div_busy, 1'b0);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  // ==========================================================================
  // main sequence; ctl is {abs second, abs first, pipe, kind}
  initial begin
    rst_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = '0;
    wdata_i = '0;
    fail_count = 0;
    checked = 0;
    rows = '{
      '{4'h2, 32'h0006_0000, 32'h0002_0000, 32'h0003_0000, 1'b0, DIV_PIPE_CYC},
      '{4'h0, 32'h8001_0000, 32'h0004_0000, 32'h8000_4000, 1'b0, DIV_UNPIPE_CYC},
      '{4'h2, 32'h0001_0000, 32'h0000_0000, 32'h7fff_ffff, 1'b0, DIV_PIPE_CYC},
      '{4'h3, 32'h0005_0000, 32'h0003_0000, 32'h0005_0000, 1'b1, 5},
      '{4'h3, 32'h8005_0000, 32'h0003_0000, 32'h0003_0000, 1'b0, 5},
      '{4'h7, 32'h8005_0000, 32'h0003_0000, 32'h8005_0000, 1'b1, 5},
      '{4'h9, 32'h0002_0000, 32'h8003_0000, 32'h8003_0000, 1'b0, 3},
      '{4'hd, 32'h8002_0000, 32'h8002_0000, 32'h8002_0000, 1'b0, 3},
      '{4'h3, 32'h0000_0000, 32'h8001_0000, 32'h0000_0000, 1'b1, 5},
      '{4'h1, 32'h0003_0000, 32'h0007_0000, 32'h0007_0000, 1'b0, 3}};
    repeat (20) @(posedge mclk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      rd(ADDR_W'(i), d);
      chk(d, '0);
    end
    wr(REG_OPA, 32'h1234_5678);
    wr(4'h7, 32'h0000_0000);
    rd(4'h5, d);
    chk(d, '0);
    rd(REG_OPA, d);
    chk(d, 32'h1234_5678);
    foreach (rows[i]) begin
      wr(REG_OPA, rows[i].a);
      wr(REG_OPB, rows[i].b);
      wr(REG_CTRL, {27'h0, rows[i].ctl, 1'b1});
      n = 0;
      while (link.y_bus !== rows[i].res && n < 20) begin
        idle(1);
        n++;
      end
      chk(32'(n), 32'(rows[i].lat + 1));
      poll();
      rd(REG_RESULT, d);
      chk(d, rows[i].res);
      if (rows[i].ctl[0]) begin
        rd(REG_STATUS, d);
        chk(d[STAT_GT_BIT], rows[i].gt);
      end
    end
    // a second start while a divide is pending must leave it alone
    wr(REG_OPA, 32'h0008_0000);
    wr(REG_OPB, 32'h0002_0000);
    wr(REG_CTRL, 32'h0000_0005);
    wr(REG_CTRL, 32'h0000_0003);
    rd(REG_CTRL, d);
    chk(d, 32'h0000_0004);
    chk(div_busy, 1'b1);
    poll();
    rd(REG_RESULT, d);
    chk(d, 32'h0004_0000);
    // reset in mid-run: a pending divide and the old result must vanish
    wr(REG_CTRL, 32'h0000_0005);
    idle(3);
    rst_i <= 1'b1;
    idle(2);
    rst_i <= 1'b0;
    chk(link.y_bus, '0);
    chk(div_busy, 1'b0);
    rd(REG_STATUS, d);
    chk(d, '0);
    idle(2);
    tally_and_finish();
  end
endmodule // fcd_tb_top
`default_nettype wire
